// ==== shared/pcq_pkg.sv ====
/*
  Constants shared by the quadrature pulse counter: register indices, field
  positions, reset values and the sampling timing.
  Assumes an APB byte address of four times the register index.
*/
package pcq_pkg;

  // Register indices; the APB byte address is four times the index.
  localparam logic [7:0] IDX_STATUS = 8'hC1;
  localparam logic [7:0] IDX_HISTORY = 8'hC2;
  localparam logic [7:0] IDX_IRQ_BASIC = 8'hC3;
  localparam logic [7:0] IDX_IRQ_ADV = 8'hC4;
  localparam logic [7:0] IDX_CNT_A_L = 8'hC5;
  localparam logic [7:0] IDX_CNT_A_M = 8'hC6;
  localparam logic [7:0] IDX_CNT_A_H = 8'hC7;
  localparam logic [7:0] IDX_CNT_B_L = 8'hC8;
  localparam logic [7:0] IDX_CNT_B_M = 8'hC9;
  localparam logic [7:0] IDX_CNT_B_H = 8'hCA;
  localparam logic [7:0] IDX_CMP_A_L = 8'hCB;
  localparam logic [7:0] IDX_CMP_A_M = 8'hCC;
  localparam logic [7:0] IDX_CMP_A_H = 8'hCD;
  localparam logic [7:0] IDX_CMP_B_L = 8'hCE;
  localparam logic [7:0] IDX_CMP_B_M = 8'hCF;
  localparam logic [7:0] IDX_CMP_B_H = 8'hD0;
  localparam logic [7:0] IDX_MODE = 8'hD9;
  localparam logic [7:0] IDX_THRESH = 8'hE4;
  localparam logic [7:0] IDX_PWR_FLAGS = 8'hE5;

  // Mode register fields and values.
  localparam int MODE_STYLE_LSB = 6;
  localparam int MODE_RATE_LSB = 4;
  localparam int MODE_HALT_BIT = 2;
  localparam int MODE_DUALSW_BIT = 1;
  localparam logic [7:0] MODE_RESET = 8'h04;
  localparam logic [7:0] MODE_WR_MASK = 8'hF6;
  localparam logic [1:0] STYLE_OFF = 2'h0;
  localparam logic [1:0] STYLE_SINGLE = 2'h1;
  localparam logic [1:0] STYLE_DUAL = 2'h2;
  localparam logic [1:0] STYLE_QUAD = 2'h3;

  // Threshold register: bit 0 is the read-valid flag, bit 1 reads zero.
  localparam int THRESH_OK_BIT = 0;
  localparam logic [7:0] THRESH_RESET = 8'h01;
  localparam logic [7:0] THRESH_WR_MASK = 8'hFC;

  // Power flags register: bit 0 wake enable, bit 1 wake pending (read only).
  localparam int PWR_WAKE_EN_BIT = 0;
  localparam int PWR_WAKE_ST_BIT = 1;

  // Basic flags in bits 3:0, their enables in bits 7:4.
  localparam int FLG_MATCH_A = 0;
  localparam int FLG_MATCH_B = 1;
  localparam int FLG_OVERFLOW = 2;
  localparam int FLG_DIR_CHANGE = 3;
  // Advanced flags in bits 2:0, their enables in bits 6:4.
  localparam int FLG_FLUT_START = 0;
  localparam int FLG_FLUT_END = 1;
  localparam int FLG_QUAD_ERR = 2;
  localparam int FLG_EN_LSB = 4;

  // Quadrature start state and flutter limit.
  localparam logic [1:0] BOTH_LOW_STATE = 2'h0;
  localparam logic [2:0] FLUTTER_LIMIT = 3'h4;

  // Sampling intervals, counted in real-time clock ticks (rounded down).
  localparam int RTC_HZ = 32768;
  localparam int SAMPLE_0_US = 250;
  localparam int SAMPLE_1_US = 500;
  localparam int SAMPLE_2_US = 1000;
  localparam int SAMPLE_3_US = 2000;
  localparam logic [6:0] SAMPLE_0_TICKS = 7'(SAMPLE_0_US * RTC_HZ / 1000000);
  localparam logic [6:0] SAMPLE_1_TICKS = 7'(SAMPLE_1_US * RTC_HZ / 1000000);
  localparam logic [6:0] SAMPLE_2_TICKS = 7'(SAMPLE_2_US * RTC_HZ / 1000000);
  localparam logic [6:0] SAMPLE_3_TICKS = 7'(SAMPLE_3_US * RTC_HZ / 1000000);

endpackage

// ==== design/pcq_sync.sv ====
/*
  Two-stage synchroniser for a bundle of independent level signals.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ns
`default_nettype none
module pcq_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== design/pcq_flutter.sv ====
/*
  One flutter counter: restarted by an edge of one input, bumped by edges of
  the other, and saturating at the flutter limit.
  Assumes single-cycle event pulses on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pcq_flutter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Events
  input wire logic clear,
  input wire logic restart,
  input wire logic bump,
  // Result
  output logic hit
);
  logic [2:0] cnt_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 3'h0;
    end else if (clear || restart) begin
      cnt_r <= 3'h0;
    end else if (bump && !hit) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

  assign hit = (cnt_r == pcq_pkg::FLUTTER_LIMIT);
endmodule
`default_nettype wire

// ==== design/pcq_top.sv ====
/*
  Quadrature pulse counter with an APB register slave: sampling, single, dual
  and quadrature counting, comparators, flutter and error flags.
  Assumes RTC_CLK, INPUT_A and INPUT_B are asynchronous and are synchronised
  here; the APB master runs on REF_CLK.
*/
// The APB register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// What this block does
// (R1) Wake only when source and wake enabled.
// (R2) Firmware checks power, then flags, clears them.
// (R3) Basic flags: match, overflow, direction change.
// (R4) Advanced flags: flutter and quadrature error.
// (R5) Real-time reads immediate; read-valid flag reports change.
// (R6) Firmware repeats reads with read-valid zero.
// (R7) Read-valid covers status, history, flags, low bytes.
// (R8) Low-byte counter read latches middle, high bytes.
// (R9) Firmware reads low byte first, then others.
// (R10) Comparator applies within two ticks of low write.
// (R11) Firmware sets comparator two counts ahead.
// (R12) Quadrature allows adjacent steps; else error.
// (R13) Quadrature starts at both-low state.
// (R14) Rising first input restarts; second-input edges bump.
// (R15) Four flutter counters, dual and quadrature modes.
// (R16) Flutter start and end raise flags.
// (R17) Halt on flutter in quadrature unless dual-switch.
// (R18) Dual-switch counts dual during flutter.
// (R19) Mode bits 7:6 select counting style.
// (R20) Mode bits 5:4 select sample interval.
// (R21) Any mode write clears both counters.
// (R22) Sampling timed by the real-time clock.
// (R23) Reset leaves counter values unchanged.
// (R24) Flags sticky until cleared; interrupt follows.
// (R25) Quadrature steps count per direction; reversal flagged.
module pcq_top (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Switch inputs and real-time clock
  input wire logic RTC_CLK,
  input wire logic INPUT_A,
  input wire logic INPUT_B,
  // Events to the system
  output logic IRQ,
  output logic WAKE
);
  logic [2:0] sync_q;
  logic rtc_prev_r;
  logic [6:0] div_r;
  logic eval_r;
  logic a_r, b_r, a_prev_r, b_prev_r;
  logic [1:0] qst_r;
  logic dir_r;
  logic flut_prev_r;
  logic [7:0] hist_r;
  logic [7:0] mode_r;
  logic [7:0] thresh_r;
  logic wake_en_r;
  logic [7:0] irq0_r;
  logic [6:0] irq1_r;
  logic [23:0] cnt_a_r, cnt_b_r;
  logic [23:0] cmp_a_sh_r, cmp_b_sh_r, cmp_a_r, cmp_b_r;
  logic cmp_a_pend_r, cmp_b_pend_r;
  logic [15:0] lat_a_r, lat_b_r;
  logic [23:0] snap_a_r, snap_b_r;
  logic [7:0] prdata_r;
  logic irq_r, wake_r;
  logic [3:0] flut_hit;

  // Bus decode.
  wire [7:0] idx = PADDR[9:2];
  wire idx_ok = (PADDR[11:10] == 2'h0) && (PADDR[1:0] == 2'h0);
  wire setup_rd = PSEL && !PENABLE && !PWRITE;
  wire wr_go = PSEL && PENABLE && PWRITE;
  wire rd_go = PSEL && PENABLE && !PWRITE;
  wire [7:0] wd = PWDATA[7:0];
  wire hit_mode = idx_ok && (idx == pcq_pkg::IDX_MODE);
  wire hit_thresh = idx_ok && (idx == pcq_pkg::IDX_THRESH);
  wire hit_irq0 = idx_ok && (idx == pcq_pkg::IDX_IRQ_BASIC);
  wire hit_irq1 = idx_ok && (idx == pcq_pkg::IDX_IRQ_ADV);
  wire hit_cnt_a_l = idx_ok && (idx == pcq_pkg::IDX_CNT_A_L);
  wire hit_cnt_b_l = idx_ok && (idx == pcq_pkg::IDX_CNT_B_L);
  wire hit_rt = idx_ok && (idx == pcq_pkg::IDX_STATUS || idx == pcq_pkg::IDX_HISTORY || hit_irq0 || hit_irq1 ||
                hit_cnt_a_l || hit_cnt_b_l); // [R7]
  wire hit_ro = idx_ok && (idx == pcq_pkg::IDX_STATUS || idx == pcq_pkg::IDX_HISTORY ||
                (idx >= pcq_pkg::IDX_CNT_A_L && idx <= pcq_pkg::IDX_CNT_B_H));
  wire hit_cmp = idx_ok && idx >= pcq_pkg::IDX_CMP_A_L && idx <= pcq_pkg::IDX_CMP_B_H;
  wire hit_any = hit_mode || hit_thresh || hit_ro || hit_irq0 || hit_irq1 || hit_cmp ||
                 (idx_ok && idx == pcq_pkg::IDX_PWR_FLAGS);
  wire mode_wr = wr_go && hit_mode;

  // Mode fields.
  wire [1:0] style = mode_r[pcq_pkg::MODE_STYLE_LSB +: 2]; // [R19]
  wire [1:0] rate = mode_r[pcq_pkg::MODE_RATE_LSB +: 2];
  wire halt_on_flutter = mode_r[pcq_pkg::MODE_HALT_BIT];
  wire flutter_dual_switch = mode_r[pcq_pkg::MODE_DUALSW_BIT];
  wire is_quad = (style == pcq_pkg::STYLE_QUAD);
  wire is_dual = (style == pcq_pkg::STYLE_DUAL);

  // Sampling divider runs on real-time clock ticks only.
  wire rtc_tick = sync_q[2] && !rtc_prev_r; // [R22]
  wire [6:0] rate_ticks = (rate == 2'h0) ? pcq_pkg::SAMPLE_0_TICKS :
                          (rate == 2'h1) ? pcq_pkg::SAMPLE_1_TICKS :
                          (rate == 2'h2) ? pcq_pkg::SAMPLE_2_TICKS : pcq_pkg::SAMPLE_3_TICKS; // [R20]
  wire div_end = (div_r >= rate_ticks - 7'h1);
  wire sample_go = rtc_tick && div_end && (style != pcq_pkg::STYLE_OFF);

  // Edges between the last two samples, valid in the evaluation cycle.
  wire a_rise = eval_r && a_r && !a_prev_r;
  wire a_fall = eval_r && !a_r && a_prev_r;
  wire b_rise = eval_r && b_r && !b_prev_r;
  wire b_fall = eval_r && !b_r && b_prev_r;

  // Quadrature order is 00, 01, 11, 10 for the forward direction.
  function automatic logic [1:0] quad_next(input logic [1:0] s);
    quad_next = {s[0], ~s[1]};
  endfunction
  wire [1:0] cur = {b_r, a_r};
  wire step_fwd = eval_r && is_quad && (cur == quad_next(qst_r)); // [R12]
  wire step_bwd = eval_r && is_quad && (qst_r == quad_next(cur)); // [R12]
  wire quad_err = eval_r && is_quad && (cur != qst_r) && !step_fwd && !step_bwd; // [R12]

  // Flutter state and the resulting counting style.
  wire flutter = (|flut_hit) && (is_quad || is_dual); // [R15]
  wire flut_start = flutter && !flut_prev_r; // [R16]
  wire flut_end = !flutter && flut_prev_r; // [R16]
  wire dual_now = is_dual || (is_quad && flutter_dual_switch && flutter); // [R18]
  wire halted = is_quad && halt_on_flutter && !flutter_dual_switch && flutter; // [R17]
  wire inc_a = !halted && ((style == pcq_pkg::STYLE_SINGLE || dual_now) ? a_fall : (is_quad && step_fwd)); // [R25]
  wire inc_b = !halted && (dual_now ? b_fall : (is_quad && step_bwd)); // [R25]
  wire quad_step = is_quad && !dual_now && !halted;
  wire dir_change = quad_step && ((step_fwd && dir_r) || (step_bwd && !dir_r)); // [R25]

  wire [23:0] cnt_a_inc = cnt_a_r + 24'h000001;
  wire [23:0] cnt_b_inc = cnt_b_r + 24'h000001;
  wire match_a = inc_a && (cnt_a_inc == cmp_a_r);
  wire match_b = inc_b && (cnt_b_inc == cmp_b_r);
  wire overflow = (inc_a && cnt_a_r == 24'hFFFFFF) || (inc_b && cnt_b_r == 24'hFFFFFF);

  // Sticky flag updates: a set in the clearing cycle wins.
  wire [3:0] set0 = {dir_change, overflow, match_b, match_a}; // [R3]
  wire [2:0] set1 = {quad_err, flut_end, flut_start}; // [R4]
  wire [3:0] keep0 = (wr_go && hit_irq0) ? wd[3:0] : 4'hF;
  wire [2:0] keep1 = (wr_go && hit_irq1) ? wd[2:0] : 3'h7;
  wire [3:0] irq0_nxt = (irq0_r[3:0] & keep0) | set0; // [R24]
  wire [2:0] irq1_nxt = (irq1_r[2:0] & keep1) | set1; // [R24]
  wire irq_any = |(irq0_r[3:0] & irq0_r[7:4]) || |(irq1_r[2:0] & irq1_r[6:4]); // [R24]

  // Register read selection.
  wire [7:0] status_val = {flutter, dir_r, qst_r, b_prev_r, a_prev_r, b_r, a_r};
  wire [7:0] rd_val =
    (idx == pcq_pkg::IDX_STATUS) ? status_val :
    (idx == pcq_pkg::IDX_HISTORY) ? hist_r :
    (idx == pcq_pkg::IDX_IRQ_BASIC) ? irq0_r :
    (idx == pcq_pkg::IDX_IRQ_ADV) ? {1'b0, irq1_r} :
    (idx == pcq_pkg::IDX_CNT_A_L) ? cnt_a_r[7:0] :
    (idx == pcq_pkg::IDX_CNT_A_M) ? lat_a_r[7:0] :
    (idx == pcq_pkg::IDX_CNT_A_H) ? lat_a_r[15:8] :
    (idx == pcq_pkg::IDX_CNT_B_L) ? cnt_b_r[7:0] :
    (idx == pcq_pkg::IDX_CNT_B_M) ? lat_b_r[7:0] :
    (idx == pcq_pkg::IDX_CNT_B_H) ? lat_b_r[15:8] :
    (idx == pcq_pkg::IDX_CMP_A_L) ? cmp_a_sh_r[7:0] :
    (idx == pcq_pkg::IDX_CMP_A_M) ? cmp_a_sh_r[15:8] :
    (idx == pcq_pkg::IDX_CMP_A_H) ? cmp_a_sh_r[23:16] :
    (idx == pcq_pkg::IDX_CMP_B_L) ? cmp_b_sh_r[7:0] :
    (idx == pcq_pkg::IDX_CMP_B_M) ? cmp_b_sh_r[15:8] :
    (idx == pcq_pkg::IDX_CMP_B_H) ? cmp_b_sh_r[23:16] :
    (idx == pcq_pkg::IDX_MODE) ? mode_r :
    (idx == pcq_pkg::IDX_THRESH) ? thresh_r :
    (idx == pcq_pkg::IDX_PWR_FLAGS) ? {6'h00, wake_r, wake_en_r} : 8'h00;

  assign PRDATA = {24'h000000, prdata_r};
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit_any;
  assign IRQ = irq_r;
  assign WAKE = wake_r;

  pcq_sync #(.W(3)) u_sync (
    .clk(REF_CLK),
    .rst_n(NRST),
    .d({RTC_CLK, INPUT_B, INPUT_A}),
    .q(sync_q)
  );

  // Counters: 0 restarts on A rise, 1 on A fall, 2 on B rise, 3 on B fall.
  wire [3:0] flut_restart = {b_fall, b_rise, a_fall, a_rise}; // [R14] [R15]
  wire [3:0] flut_bump = {{2{a_rise || a_fall}}, {2{b_rise || b_fall}}}; // [R14] [R15]
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_flut
      pcq_flutter u_flut (
        .clk(REF_CLK),
        .rst_n(NRST),
        .clear(mode_wr),
        .restart(flut_restart[gi]),
        .bump(flut_bump[gi]),
        .hit(flut_hit[gi])
      );
    end
  endgenerate

  // Sampling, quadrature tracking and status history.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      rtc_prev_r <= 1'b0;
      div_r <= 7'h00;
      eval_r <= 1'b0;
      a_r <= 1'b0;
      b_r <= 1'b0;
      a_prev_r <= 1'b0;
      b_prev_r <= 1'b0;
      qst_r <= pcq_pkg::BOTH_LOW_STATE;
      dir_r <= 1'b0;
      flut_prev_r <= 1'b0;
      hist_r <= 8'h00;
    end else begin
      rtc_prev_r <= sync_q[2];
      eval_r <= sample_go && !mode_wr;
      flut_prev_r <= flutter;
      if (mode_wr) begin
        div_r <= 7'h00;
        qst_r <= pcq_pkg::BOTH_LOW_STATE; // [R13]
        dir_r <= 1'b0;
      end else begin
        if (rtc_tick) begin
          div_r <= div_end ? 7'h00 : div_r + 7'h01; // [R22]
        end
        if (sample_go) begin
          a_r <= sync_q[0];
          b_r <= sync_q[1];
          a_prev_r <= a_r;
          b_prev_r <= b_r;
        end
        if (eval_r && is_quad) begin
          qst_r <= cur; // [R12]
        end
        if (quad_step && (step_fwd || step_bwd)) begin
          dir_r <= step_bwd; // [R25]
        end
        if (eval_r && cur != {b_prev_r, a_prev_r}) begin
          hist_r <= {hist_r[5:0], cur};
        end
      end
    end
  end

  // Counters keep their value across reset; only a mode write clears them.
  always_ff @(posedge REF_CLK) begin
    if (mode_wr) begin
      cnt_a_r <= 24'h000000; // [R21] [R23]
      cnt_b_r <= 24'h000000; // [R21] [R23]
    end else begin
      if (inc_a) begin
        cnt_a_r <= cnt_a_inc;
      end
      if (inc_b) begin
        cnt_b_r <= cnt_b_inc;
      end
    end
  end

  // Comparators: shadow bytes, applied at the next real-time tick after the low byte.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      cmp_a_sh_r <= 24'hFFFFFF;
      cmp_b_sh_r <= 24'hFFFFFF;
      cmp_a_r <= 24'hFFFFFF;
      cmp_b_r <= 24'hFFFFFF;
      cmp_a_pend_r <= 1'b0;
      cmp_b_pend_r <= 1'b0;
    end else begin
      if (wr_go && idx_ok) begin
        if (idx == pcq_pkg::IDX_CMP_A_L) cmp_a_sh_r[7:0] <= wd;
        if (idx == pcq_pkg::IDX_CMP_A_M) cmp_a_sh_r[15:8] <= wd;
        if (idx == pcq_pkg::IDX_CMP_A_H) cmp_a_sh_r[23:16] <= wd;
        if (idx == pcq_pkg::IDX_CMP_B_L) cmp_b_sh_r[7:0] <= wd;
        if (idx == pcq_pkg::IDX_CMP_B_M) cmp_b_sh_r[15:8] <= wd;
        if (idx == pcq_pkg::IDX_CMP_B_H) cmp_b_sh_r[23:16] <= wd;
      end
      if (wr_go && idx_ok && idx == pcq_pkg::IDX_CMP_A_L) begin
        cmp_a_pend_r <= 1'b1;
      end else if (rtc_tick && cmp_a_pend_r) begin
        cmp_a_r <= cmp_a_sh_r; // [R10]
        cmp_a_pend_r <= 1'b0;
      end
      if (wr_go && idx_ok && idx == pcq_pkg::IDX_CMP_B_L) begin
        cmp_b_pend_r <= 1'b1;
      end else if (rtc_tick && cmp_b_pend_r) begin
        cmp_b_r <= cmp_b_sh_r; // [R10]
        cmp_b_pend_r <= 1'b0;
      end
    end
  end

  // Control registers, flags and outputs.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      mode_r <= pcq_pkg::MODE_RESET;
      thresh_r <= pcq_pkg::THRESH_RESET;
      wake_en_r <= 1'b0;
      irq0_r <= 8'h00;
      irq1_r <= 7'h00;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      if (mode_wr) begin
        mode_r <= (wd & pcq_pkg::MODE_WR_MASK) | (mode_r & ~pcq_pkg::MODE_WR_MASK);
      end
      if (wr_go && hit_thresh) begin
        thresh_r <= (wd & pcq_pkg::THRESH_WR_MASK) | (thresh_r & ~pcq_pkg::THRESH_WR_MASK);
      end else if (rd_go && hit_rt) begin
        thresh_r[pcq_pkg::THRESH_OK_BIT] <= (rd_val == prdata_r); // [R5]
      end
      if (wr_go && idx_ok && idx == pcq_pkg::IDX_PWR_FLAGS) begin
        wake_en_r <= wd[pcq_pkg::PWR_WAKE_EN_BIT];
      end
      if (wr_go && hit_irq0) begin
        irq0_r[7:4] <= wd[7:4];
      end
      if (wr_go && hit_irq1) begin
        irq1_r[6:4] <= wd[6:4];
      end
      irq0_r[3:0] <= irq0_nxt;
      irq1_r[2:0] <= irq1_nxt;
      irq_r <= irq_any;
      wake_r <= irq_any && wake_en_r; // [R1]
    end
  end

  // Read data is taken at setup; the access phase of a real-time read checks it still holds.
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      prdata_r <= 8'h00;
    end else if (setup_rd) begin
      prdata_r <= hit_any ? rd_val : 8'h00; // [R5]
    end
  end

  // Low-byte reads latch the upper bytes of the snapshot taken at setup.
  always_ff @(posedge REF_CLK) begin
    if (setup_rd) begin
      snap_a_r <= cnt_a_r;
      snap_b_r <= cnt_b_r;
    end
    if (rd_go && hit_cnt_a_l) begin
      lat_a_r <= snap_a_r[23:8]; // [R8]
    end
    if (rd_go && hit_cnt_b_l) begin
      lat_b_r <= snap_b_r[23:8]; // [R8]
    end
  end
endmodule
`default_nettype wire

// ==== verification/pcq_top_properties.sv ====
/*
  Checker bound to pcq_top: APB answer, read data and event outputs.
  Assumes a master that keeps the APB setup and access phases.
*/
`timescale 1ns/1ns
`default_nettype none
module pcq_top_properties (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Events
  input wire logic IRQ,
  input wire logic WAKE
);
  logic acc;
  logic rd_setup;
  assign acc = PSEL && PENABLE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!NRST);
  chk_ready_high: assert property (PREADY)
    else $error("pready low");
  chk_setup_no_err: assert property (PSEL && !PENABLE |-> !PSLVERR)
    else $error("error in setup phase");
  chk_unmapped_err: assert property (acc && PADDR[9:2] == 8'h00 |-> PSLVERR)
    else $error("unmapped access not refused");
  chk_mode_no_err: assert property (acc && PADDR == {2'h0, pcq_pkg::IDX_MODE, 2'h0} |-> !PSLVERR)
    else $error("mode access refused");
  chk_rdata_upper: assert property (PRDATA[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_rdata_hold: assert property (!rd_setup |=> $stable(PRDATA))
    else $error("read data changed without read");
  chk_wake_needs_irq: assert property (WAKE |-> IRQ)
    else $error("wake without interrupt");
  chk_irq_fall_write: assert property ($fell(IRQ) && $past(NRST) |-> $past(acc && PWRITE) || $past(acc && PWRITE, 2))
    else $error("interrupt dropped without write");
  chk_reset_quiet: assert property ($rose(NRST) |-> !IRQ && !WAKE)
    else $error("event active after reset");
  cover property (acc && !PWRITE);
  cover property ($rose(IRQ));
  cover property ($rose(WAKE));
endmodule
bind pcq_top pcq_top_properties pcq_top_properties_inst (
  .REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .WAKE(WAKE)
);
`default_nettype wire

// ==== verification/pcq_reed_model.sv ====
/*
  Model of the two switches or the encoder on the counter inputs.
  Assumes its task is called just after a rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pcq_reed_model (
  // Clock
  input wire logic clk,
  // Switch lines
  output logic a,
  output logic b
);
  initial begin
    a = 1'b0;
    b = 1'b0;
  end
  // Each code is held for over one sample interval at rates 0 and 1, so it is seen at those rates.
  task automatic put(input logic [1:0] v);
    {b, a} <= v;
    repeat (300) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== verification/pulse_counter_quadrature_tb.sv ====
/*
  Self-checking bench for pcq_top: registers over APB, counting modes, flags.
  Assumes pcq_top and pcq_reed_model; the real-time clock is sped up.
*/
`timescale 1ns/1ns
`default_nettype none
module pulse_counter_quadrature_tb;
  logic REF_CLK, NRST, PSEL, PENABLE, PWRITE, RTC_CLK, INPUT_A, INPUT_B;
  logic PREADY, PSLVERR, IRQ, WAKE, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [7:0] rv;
  int num_errors = 0;
  int total_checks = 0;
  pcq_top pcq_top_inst (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RTC_CLK(RTC_CLK),
    .INPUT_A(INPUT_A), .INPUT_B(INPUT_B), .IRQ(IRQ), .WAKE(WAKE));
  pcq_reed_model pcq_reed_model_inst (.clk(REF_CLK), .a(INPUT_A), .b(INPUT_B));
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  // The real-time clock toggles every five system cycles, driven like any other input.
  initial begin
    RTC_CLK = 1'b0;
    forever begin
      repeat (5) @(posedge REF_CLK);
      RTC_CLK <= ~RTC_CLK;
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {2'h0, idx, 2'h0};
    PWDATA <= {24'h0, d};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) begin
      @(posedge REF_CLK);
    end
    rv = PRDATA[7:0];
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string m);
    apb(1'b0, idx, 8'h00);
    chk(rv, exp, m);
  endtask
  // Low byte first, then the read-valid flag, then the latched bytes.
  task automatic rdcnt(input logic [7:0] idx, input logic [23:0] exp, input string m);
    rd(idx, exp[7:0], m);
    rd(pcq_pkg::IDX_THRESH, 8'h01, "read valid");
    rd(idx + 8'h01, exp[15:8], m);
    rd(idx + 8'h02, exp[23:16], m);
  endtask
  task automatic t_reset();
    rd(pcq_pkg::IDX_MODE, 8'h04, "mode reset");
    rd(pcq_pkg::IDX_THRESH, 8'h01, "thresh reset");
    rd(pcq_pkg::IDX_CMP_A_L, 8'hFF, "cmp reset");
    apb(1'b0, 8'h00, 8'h00);
    chk({7'h0, err}, 8'h01, "unmapped refused");
  endtask
  task automatic t_quad();
    logic [1:0] fwd [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    apb(1'b1, pcq_pkg::IDX_MODE, 8'hC0);
    rdcnt(pcq_pkg::IDX_CNT_A_L, 24'h0, "cleared");
    for (int i = 0; i < 4; i++) pcq_reed_model_inst.put(fwd[i]);
    rdcnt(pcq_pkg::IDX_CNT_A_L, 24'h4, "forward");
    rd(pcq_pkg::IDX_IRQ_ADV, 8'h00, "no start error");
    apb(1'b1, pcq_pkg::IDX_CMP_A_H, 8'h00);
    apb(1'b1, pcq_pkg::IDX_CMP_A_M, 8'h00);
    apb(1'b1, pcq_pkg::IDX_CMP_A_L, 8'h06);
    apb(1'b1, pcq_pkg::IDX_IRQ_BASIC, 8'h10);
    apb(1'b1, pcq_pkg::IDX_PWR_FLAGS, 8'h01);
    pcq_reed_model_inst.put(2'h1);
    pcq_reed_model_inst.put(2'h3);
    chk({6'h0, WAKE, IRQ}, 8'h03, "match wake");
    rd(pcq_pkg::IDX_IRQ_BASIC, 8'h11, "match flag");
    apb(1'b1, pcq_pkg::IDX_IRQ_BASIC, 8'h10);
    repeat (4) @(posedge REF_CLK);
    chk({6'h0, WAKE, IRQ}, 8'h00, "cleared irq");
    pcq_reed_model_inst.put(2'h1);
    rdcnt(pcq_pkg::IDX_CNT_B_L, 24'h1, "backward");
    rd(pcq_pkg::IDX_IRQ_BASIC, 8'h18, "dir change");
    pcq_reed_model_inst.put(2'h2);
    rd(pcq_pkg::IDX_IRQ_ADV, 8'h04, "quad error");
  endtask
  task automatic t_flutter();
    apb(1'b1, pcq_pkg::IDX_IRQ_ADV, 8'h00);
    apb(1'b1, pcq_pkg::IDX_MODE, 8'h80);
    pcq_reed_model_inst.put(2'h0);
    pcq_reed_model_inst.put(2'h2);
    pcq_reed_model_inst.put(2'h0);
    pcq_reed_model_inst.put(2'h2);
    rd(pcq_pkg::IDX_IRQ_ADV, 8'h01, "flutter start");
    pcq_reed_model_inst.put(2'h3);
    pcq_reed_model_inst.put(2'h2);
    rd(pcq_pkg::IDX_IRQ_ADV, 8'h03, "flutter end");
    rdcnt(pcq_pkg::IDX_CNT_B_L, 24'h2, "dual b");
    rdcnt(pcq_pkg::IDX_CNT_A_L, 24'h1, "dual a");
  endtask
  // Quadrature steps on B raise flutter, then A steps while halted or switched to dual counting.
  task automatic t_quad_flutter(input logic [7:0] md, input logic [7:0] ea);
    pcq_reed_model_inst.put(2'h0);
    apb(1'b1, pcq_pkg::IDX_MODE, md);
    apb(1'b1, pcq_pkg::IDX_IRQ_ADV, 8'h00);
    pcq_reed_model_inst.put(2'h2);
    pcq_reed_model_inst.put(2'h0);
    pcq_reed_model_inst.put(2'h2);
    pcq_reed_model_inst.put(2'h0);
    pcq_reed_model_inst.put(2'h1);
    pcq_reed_model_inst.put(2'h0);
    rd(pcq_pkg::IDX_IRQ_ADV, 8'h03, "quad flutter flags");
    rdcnt(pcq_pkg::IDX_CNT_A_L, {16'h0000, ea}, "quad flutter a");
    rdcnt(pcq_pkg::IDX_CNT_B_L, 24'h2, "quad flutter b");
  endtask
  task automatic t_single();
    apb(1'b1, pcq_pkg::IDX_IRQ_BASIC, 8'h00);
    apb(1'b1, pcq_pkg::IDX_PWR_FLAGS, 8'h00);
    apb(1'b1, pcq_pkg::IDX_MODE, 8'h50);
    pcq_reed_model_inst.put(2'h3);
    pcq_reed_model_inst.put(2'h2);
    rdcnt(pcq_pkg::IDX_CNT_A_L, 24'h1, "single");
    NRST <= 1'b0;
    repeat (6) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    rdcnt(pcq_pkg::IDX_CNT_A_L, 24'h1, "persist");
    apb(1'b1, pcq_pkg::IDX_MODE, 8'h00);
    pcq_reed_model_inst.put(2'h3);
    pcq_reed_model_inst.put(2'h2);
    rdcnt(pcq_pkg::IDX_CNT_A_L, 24'h0, "disabled");
  endtask
  initial begin
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    repeat (6) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    t_reset();
    t_quad();
    t_flutter();
    t_quad_flutter(8'hC2, 8'h03);
    t_quad_flutter(8'hC4, 8'h02);
    t_single();
    final_report();
  end
  initial begin
    repeat (60000) @(posedge REF_CLK);
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule
`default_nettype wire
